// ---- design/mcf_frame_interpreter.sv ----
// Slave-side binary command frame interpreter with reply generator
// Notes on behaviour
// - Transmit only in answer to a command
// - Link stays receiving except during execution, reply and text mode
// - Reply only after execution has finished
// - Exactly one reply per accepted command
// - Core is code, type, selector, value
// - Byte link frame: address, core, checksum
// - Value bytes arrive most significant first
// - Command checksum sums eight preceding bytes
// - Reply: host, module, status, code, value, sum
// - Reply checksum sums all other bytes
// - CAN command carries no address, no checksum
// - CAN reply drops address and checksum
// - Status 100 executed, 101 stored
// - Failure codes one to six reported
// - Commands executed or stored for programs
// - Code 139 switches to text mode
`timescale 1ns/1ps
`default_nettype none
module mcf_frame_interpreter (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// Configuration
	input  wire logic [7:0]          moduleAddr,
	input  wire logic [7:0]          hostAddr,
	input  wire logic                canMode,
	input  wire logic                storeMode,
	// Receive byte stream
	input  wire logic                rxValid,
	input  wire logic [7:0]          rxData,
	output logic                     rxReady,
	// Execution port
	output logic                     execValid,
	output mcf_pkg::mcf_cmd_t        execCmd,
	output logic                     execStore,
	input  wire logic                execDone,
	input  wire mcf_pkg::mcf_result_t execResult,
	// Transmit byte stream
	output logic                     txValid,
	output logic [7:0]               txData,
	output logic                     txLast,
	input  wire logic                txReady,
	output logic                     txDrive,
	// Text mode hand-off
	output logic                     textMode,
	input  wire logic                textModeExit
);
	import mcf_pkg::*;

	// ==========================================================
	// Reply byte selection
	function automatic logic [7:0] replyByte(input logic [3:0] idx,
		input logic [7:0] host, modA, status, code,
		input logic [31:0] value);
		logic [7:0] b;
		b = BYTE_ZERO;
		case (idx)
			RIDX_HOST:   b = host;
			RIDX_MOD:    b = modA;
			RIDX_STATUS: b = status;
			RIDX_CMD:    b = code;
			4'h4:        b = value[31:24];
			4'h5:        b = value[23:16];
			4'h6:        b = value[15:8];
			4'h7:        b = value[7:0];
			default:     b = BYTE_ZERO;
		endcase
		return b;
	endfunction : replyByte

	// ==========================================================
	// Declarations
	mcf_state_t  state_reg;
	mcf_cmd_t    frame_reg;
	logic [3:0]  rxIdx_reg;
	logic        addrOk_reg;
	logic        execValid_reg;
	logic        store_reg;
	logic [7:0]  status_reg;
	logic [31:0] value_reg;
	logic [3:0]  txIdx_reg;
	logic [7:0]  txData_reg;
	logic        textMode_reg;
	logic [7:0]  rxSum, txSum, status_next;
	logic [3:0]  rxPos, firstIdx, lastIdx, txIdx_next;
	logic        rxHs, rxEnd, addrMatch, sumOk, frameOk;
	logic        sumBadEnd, addrMiss, execEnd, enterReply, txHs;
	logic        execOpen_reg;

	// ==========================================================
	// Link framing
	assign firstIdx = canMode ? IDX_CMD : IDX_ADDR;
	assign lastIdx  = canMode ? IDX_VAL3 : IDX_SUM;
	assign rxPos    = rxIdx_reg + {3'b000, canMode};
	assign rxReady  = (state_reg == S_RECV) && !textMode_reg;
	assign rxHs     = rxValid && rxReady;
	assign rxEnd    = rxHs && (rxPos == lastIdx);
	assign addrMatch = canMode || addrOk_reg;
	assign sumOk    = canMode || (rxSum == rxData);
	assign frameOk  = rxEnd && addrMatch && sumOk;
	assign sumBadEnd = rxEnd && addrMatch && !sumOk;
	assign addrMiss = rxEnd && !addrMatch;
	assign execEnd  = (state_reg == S_EXEC) && execDone;
	assign enterReply = sumBadEnd || execEnd;
	assign txHs     = txValid && txReady;
	assign txIdx_next = txIdx_reg + 4'h1;

	// ==========================================================
	// Receive byte counter and frame fields
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			rxIdx_reg <= 4'h0;
		else if (rxEnd)
			rxIdx_reg <= 4'h0;
		else if (rxHs)
			rxIdx_reg <= rxIdx_reg + 4'h1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			frame_reg  <= '0;
			addrOk_reg <= 1'b0;
		end
		else if (rxHs)
		begin
			case (rxPos)
				IDX_ADDR: addrOk_reg <= (rxData == moduleAddr);
				IDX_CMD:  frame_reg.code <= rxData;
				IDX_TYPE: frame_reg.kind <= rxData;
				IDX_SEL:  frame_reg.sel <= rxData;
				IDX_SUM:  addrOk_reg <= addrOk_reg;
				default:  frame_reg.value <= {frame_reg.value[23:0], rxData};
			endcase
		end
	end

	mcf_sum_acc #(.W(8)) uRxSum (
		.clk    (clk),
		.rst_n  (rst_n),
		.clear  (rxEnd),
		.add    (rxHs && !rxEnd),
		.dataIn (rxData),
		.sum    (rxSum)
	);

	// ==========================================================
	// Control state machine
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			state_reg <= S_RECV;
		else
		begin
			case (state_reg)
				S_RECV:
					if (frameOk)
						state_reg <= S_EXEC;
					else if (sumBadEnd)
						state_reg <= S_REPLY;
				S_EXEC:
					if (execDone)
						state_reg <= S_REPLY;
				S_REPLY:
					if (txHs && txLast)
						state_reg <= S_RECV;
				default:
					state_reg <= S_RECV;
			endcase
		end
	end

	// ==========================================================
	// Execution request
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			execValid_reg <= 1'b0;
			store_reg     <= 1'b0;
		end
		else
		begin
			execValid_reg <= frameOk;
			if (frameOk)
				store_reg <= storeMode;
		end
	end

	assign execValid = execValid_reg;
	assign execCmd   = frame_reg;
	assign execStore = store_reg;

	// ==========================================================
	// Reply status and value
	always_comb
	begin
		status_next = execResult.status;
		if (store_reg && execResult.status == ST_OK)
			status_next = ST_STORED;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			status_reg <= BYTE_ZERO;
			value_reg  <= VALUE_ZERO;
		end
		else if (sumBadEnd)
		begin
			status_reg <= ST_BAD_SUM;
			value_reg  <= VALUE_ZERO;
		end
		else if (execEnd)
		begin
			status_reg <= status_next;
			value_reg  <= execResult.value;
		end
	end

	// ==========================================================
	// Reply serialiser
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			txIdx_reg  <= 4'h0;
			txData_reg <= BYTE_ZERO;
		end
		else if (enterReply)
		begin
			txIdx_reg  <= firstIdx;
			txData_reg <= replyByte(firstIdx, hostAddr, moduleAddr,
				status_reg, frame_reg.code, value_reg);
		end
		else if (txHs && !txLast)
		begin
			txIdx_reg <= txIdx_next;
			if (txIdx_next == IDX_SUM)
				txData_reg <= txSum;
			else
				txData_reg <= replyByte(txIdx_next, hostAddr, moduleAddr,
					status_reg, frame_reg.code, value_reg);
		end
	end

	mcf_sum_acc #(.W(8)) uTxSum (
		.clk    (clk),
		.rst_n  (rst_n),
		.clear  (enterReply),
		.add    (enterReply || (txHs && !txLast)),
		.dataIn (enterReply ? replyByte(firstIdx, hostAddr, moduleAddr,
			status_reg, frame_reg.code, value_reg)
			: replyByte(txIdx_next, hostAddr, moduleAddr,
			status_reg, frame_reg.code, value_reg)),
		.sum    (txSum)
	);

	assign txValid = (state_reg == S_REPLY);
	assign txDrive = (state_reg == S_REPLY);
	assign txData  = txData_reg;
	assign txLast  = (txIdx_reg == lastIdx);

	// ==========================================================
	// Text mode switch, set wins over exit
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			textMode_reg <= 1'b0;
		else if (txHs && txLast && frame_reg.code == CMD_TEXT_MODE
			&& status_reg == ST_OK)
			textMode_reg <= 1'b1;
		else if (textModeExit)
			textMode_reg <= 1'b0;
	end
	assign textMode = textMode_reg;

	// ==========================================================
	// Checks
	function automatic logic [7:0] expSum(input logic [7:0] host, modA,
		status, code, input logic [31:0] value);
		logic [7:0] s;
		s = BYTE_ZERO;
		for (int i = 0; i < 8; i++)
			s = s + replyByte(4'(i), host, modA, status, code, value);
		return s;
	endfunction : expSum
	always_ff @(posedge clk)
	begin
		execOpen_reg <= rst_n && (execOpen_reg || execValid) && !execDone;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_tx_has_cause: assert property ($rose(txDrive) |->
		$past(sumBadEnd) || $past(execEnd))
		else $error("reply started without a command");
	a_rx_while_tx: assert property (txDrive |-> !rxReady)
		else $error("receiver open while driving");
	a_no_tx_in_exec: assert property ((execValid || execOpen_reg) |->
		!txDrive)
		else $error("reply before execution ended");
	a_one_reply: assert property ((txHs && txLast) |=>
		!txDrive [*2])
		else $error("second reply after one command");
	a_bad_sum: assert property (sumBadEnd |=>
		txDrive && status_reg == ST_BAD_SUM && !execValid)
		else $error("bad checksum not refused");
	a_addr_filter: assert property (addrMiss |=>
		!execValid && !txDrive && rxReady)
		else $error("foreign frame not ignored");
	a_reply_sum: assert property ((txHs && !canMode &&
		txIdx_reg == IDX_SUM) |-> txData == expSum(hostAddr,
		moduleAddr, status_reg, frame_reg.code, value_reg))
		else $error("reply checksum wrong");
	a_store_code: assert property ((execEnd && store_reg &&
		execResult.status == ST_OK) |=> status_reg == ST_STORED)
		else $error("stored command not reported 101");
	a_can_length: assert property ((canMode && txHs &&
		txIdx_reg == IDX_VAL3) |-> txLast)
		else $error("CAN reply too long");
	a_text_switch: assert property ((txHs && txLast &&
		frame_reg.code == CMD_TEXT_MODE && status_reg == ST_OK)
		|=> textMode && !rxReady)
		else $error("text mode not entered");
	c_ok_reply: cover property (execEnd && execResult.status == ST_OK
		##[1:20] (txHs && txLast));
	c_bad_sum: cover property (sumBadEnd);
	c_addr_miss: cover property (addrMiss);
	c_text_mode: cover property ($rose(textMode));
endmodule : mcf_frame_interpreter
`default_nettype wire

// ---- design/mcf_pkg.sv ----
// Shared constants and types for the motion command frame interpreter
package mcf_pkg;

	// ==========================================================
	// Frame layout: byte positions on a byte-oriented link
	localparam logic [3:0] IDX_ADDR  = 4'h0;
	localparam logic [3:0] IDX_CMD   = 4'h1;
	localparam logic [3:0] IDX_TYPE  = 4'h2;
	localparam logic [3:0] IDX_SEL   = 4'h3;
	localparam logic [3:0] IDX_VAL0  = 4'h4;
	localparam logic [3:0] IDX_VAL3  = 4'h7;
	localparam logic [3:0] IDX_SUM   = 4'h8;

	// ==========================================================
	// Reply layout: byte positions on a byte-oriented link
	localparam logic [3:0] RIDX_HOST   = 4'h0;
	localparam logic [3:0] RIDX_MOD    = 4'h1;
	localparam logic [3:0] RIDX_STATUS = 4'h2;
	localparam logic [3:0] RIDX_CMD    = 4'h3;

	// ==========================================================
	// Status codes
	localparam logic [7:0] ST_OK        = 8'h64;
	localparam logic [7:0] ST_STORED    = 8'h65;
	localparam logic [7:0] ST_BAD_SUM   = 8'h01;
	localparam logic [7:0] ST_BAD_CMD   = 8'h02;
	localparam logic [7:0] ST_BAD_TYPE  = 8'h03;
	localparam logic [7:0] ST_BAD_VALUE = 8'h04;
	localparam logic [7:0] ST_LOCKED    = 8'h05;
	localparam logic [7:0] ST_NOT_AVAIL = 8'h06;

	// ==========================================================
	// Command codes and reset values
	localparam logic [7:0]  CMD_TEXT_MODE = 8'h8B;
	localparam logic [7:0]  BYTE_ZERO     = 8'h00;
	localparam logic [31:0] VALUE_ZERO    = 32'h0000_0000;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [7:0]  code;
		logic [7:0]  kind;
		logic [7:0]  sel;
		logic [31:0] value;
	} mcf_cmd_t;

	typedef struct packed {
		logic [7:0]  status;
		logic [31:0] value;
	} mcf_result_t;

	typedef enum logic [2:0] {
		S_RECV  = 3'b001,
		S_EXEC  = 3'b010,
		S_REPLY = 3'b100
	} mcf_state_t;

endpackage : mcf_pkg

// ---- design/mcf_sum_acc.sv ----
// Wrapping byte accumulator for frame checksums
`timescale 1ns/1ps
`default_nettype none
module mcf_sum_acc #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Accumulate control
	input  wire logic         clear,
	input  wire logic         add,
	input  wire logic [W-1:0] dataIn,
	// Running sum
	output logic      [W-1:0] sum
);

	// ==========================================================
	// Parameter check
	if (W != 8)
	begin : g_bad_width
		$error("mcf_sum_acc: only 8-bit sums are served");
	end

	// ==========================================================
	// Accumulator, clear restarts with the current byte
	logic [W-1:0] sum_reg;
	logic [W-1:0] sum_next;

	always_comb
	begin
		sum_next = (clear ? '0 : sum_reg) + (add ? dataIn : '0);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sum_reg <= '0;
		else
			sum_reg <= sum_next;
	end

	assign sum = sum_reg;

endmodule : mcf_sum_acc
`default_nettype wire

// ---- dv/mcf_exec_model.sv ----
// Executor model that answers each command after a chosen delay
`timescale 1ns/1ps
`default_nettype none
module mcf_exec_model (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// Answer shaping from the bench
	input  wire logic [3:0]            delay,
	input  wire logic [7:0]            status,
	// Execution port
	input  wire logic                  execValid,
	input  wire mcf_pkg::mcf_cmd_t     execCmd,
	output logic                       execDone,
	output var mcf_pkg::mcf_result_t   execResult
);
	import mcf_pkg::*;
	logic       busy;
	logic [3:0] cnt;

	// ==========================================================
	// Answer after the delay, result lines toggle outside the pulse
	always @(posedge clk)
	begin
		execDone <= 1'b0;
		execResult <= ~execResult;
		if (!rst_n)
		begin
			busy <= 1'b0;
			execResult <= '0;
		end
		else if (execValid)
		begin
			busy <= 1'b1;
			cnt <= delay;
		end
		else if (busy && cnt == 4'h0)
		begin
			busy <= 1'b0;
			execDone <= 1'b1;
			execResult <= {status, execCmd.value ^ 32'hFFFF_0000};
		end
		else if (busy)
			cnt <= cnt - 4'h1;
	end
endmodule : mcf_exec_model
`default_nettype wire

// ---- dv/tb_top.sv ----
// Self-checking bench for the command frame interpreter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mcf_pkg::*;
	logic        clk = 1'b0, rst_n = 1'b0, canMode = 1'b0;
	logic        storeMode = 1'b0, rxValid = 1'b0, txReady = 1'b0;
	logic        textModeExit = 1'b0, expectTx = 1'b0, pend = 1'b0;
	logic [7:0]  moduleAddr = 8'h05, hostAddr = 8'h02, rxData = 8'h00;
	logic [7:0]  exStatus = 8'h64, txData;
	logic [3:0]  exDelay = 4'h0;
	logic        rxReady, execValid, execStore, execDone;
	logic        txValid, txLast, txDrive, textMode;
	mcf_cmd_t    execCmd;
	mcf_result_t execResult;
	int          num_errors = 0, compares = 0, execCnt = 0, cycles = 0;
	logic [7:0]  fr [9];
	logic [7:0]  rep [9];
	logic [7:0]  okSt [6] = '{8'h64, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};

	mcf_frame_interpreter dut (.clk(clk), .rst_n(rst_n),
		.moduleAddr(moduleAddr), .hostAddr(hostAddr), .canMode(canMode),
		.storeMode(storeMode), .rxValid(rxValid), .rxData(rxData),
		.rxReady(rxReady), .execValid(execValid), .execCmd(execCmd),
		.execStore(execStore), .execDone(execDone),
		.execResult(execResult), .txValid(txValid), .txData(txData),
		.txLast(txLast), .txReady(txReady), .txDrive(txDrive),
		.textMode(textMode), .textModeExit(textModeExit));
	mcf_exec_model exec_model (.clk(clk), .rst_n(rst_n), .delay(exDelay),
		.status(exStatus), .execValid(execValid), .execCmd(execCmd),
		.execDone(execDone), .execResult(execResult));

	// ==========================================================
	// Clock, timeout and link monitor
	always #5 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles > 20000)
		begin
			num_errors++;
			stop_test();
		end
		if (!rst_n)
			pend = 1'b0;
		else
		begin
			if (execValid === 1'b1)
			begin
				execCnt++;
				pend = 1'b1;
			end
			if (execDone === 1'b1)
				pend = 1'b0;
			if (txValid === 1'b1 && (!expectTx || pend)) err("early tx");
			if (txDrive !== txValid) err("driver enable differs");
		end
	end

	task automatic err(input string m);
		num_errors++;
		$display("FAIL %0t: %s", $time, m);
	endtask : err

	task automatic stop_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	function automatic logic [7:0] sum8(input logic [7:0] b [9]);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 8; i++)
			s += b[i];
		return s;
	endfunction : sum8

	task automatic do_reset();
		rst_n = 1'b0;
		repeat (12) @(posedge clk);
		#1 rst_n = 1'b1;
		compares++;
		if (rxReady !== 1'b1 || txValid !== 1'b0 || textMode !== 1'b0) err("reset state");
	endtask : do_reset

	task automatic send_byte(input logic [7:0] b);
		logic ok;
		rxValid = 1'b1;
		rxData = b;
		ok = 1'b0;
		while (!ok)
		begin
			ok = rxReady;
			@(posedge clk);
			#1;
		end
	endtask : send_byte

	// ==========================================================
	// One command frame and its reply
	task automatic run_cmd(input logic [7:0] ad, c, k, s,
		input logic [31:0] v, input logic bad, sto, input logic [7:0] st);
		logic [55:0] core;
		logic [7:0]  es, d;
		logic [31:0] ev;
		logic        took, l;
		int          n, base, i, t, e0;
		n = canMode ? 7 : 9;
		base = canMode ? 0 : 1;
		core = {c, k, s, v};
		fr[0] = ad;
		for (i = 0; i < 7; i++)
			fr[i + base] = core[55 - 8 * i -: 8];
		fr[8] = sum8(fr) + {7'h00, bad};
		exStatus = st;
		exDelay = 4'($urandom % 12);
		storeMode = sto;
		e0 = execCnt;
		for (i = 0; i < n; i++)
			send_byte(fr[i]);
		rxValid = 1'b0;
		if (!canMode && ad != moduleAddr)
		begin
			repeat (30) @(posedge clk);
			#1;
			compares++;
			if (execCnt != e0) err("foreign frame executed");
			return;
		end
		expectTx = 1'b1;
		compares++;
		if (rxReady !== 1'b0) err("link not held off");
		es = bad ? ST_BAD_SUM : (sto && st == ST_OK) ? ST_STORED : st;
		ev = bad ? VALUE_ZERO : v ^ 32'hFFFF_0000;
		core = {moduleAddr, es, c, ev};
		rep[0] = hostAddr;
		for (i = 0; i < 7; i++)
			rep[i + base] = core[55 - 8 * i -: 8];
		rep[8] = sum8(rep);
		i = 0;
		t = 0;
		while (i < n && t < 300)
		begin
			txReady = ($urandom % 3) != 0;
			took = txValid & txReady;
			d = txData;
			l = txLast;
			@(posedge clk);
			#1;
			t++;
			if (took === 1'b1)
			begin
				compares++;
				if (d !== rep[i] || l !== (i == n - 1)) err("reply byte");
				i++;
			end
		end
		txReady = 1'b0;
		compares++;
		if (i != n || txValid !== 1'b0) err("reply length");
		compares++;
		if (execCnt - e0 != (bad ? 0 : 1)) err("exec count");
		compares++;
		if (!bad && (execCmd !== core_of(c, k, s, v) || execStore !== sto)) err("exec fields");
		expectTx = 1'b0;
	endtask : run_cmd

	function automatic mcf_cmd_t core_of(input logic [7:0] c, k, s,
		input logic [31:0] v);
		return {c, k, s, v};
	endfunction : core_of

	// ==========================================================
	// Main sequence
	initial
	begin
		logic [7:0] c;
		void'($urandom(85));
		#1;
		do_reset();
		run_cmd(8'h05, 8'hFF, 8'hFF, 8'hFF, 32'hFFFF_FFFF, 0, 0, ST_OK);
		run_cmd(8'h05, 8'h01, 8'h00, 8'h00, 32'h1234_5678, 1, 0, ST_OK);
		run_cmd(8'h07, 8'h01, 8'h00, 8'h00, 32'h0000_0000, 0, 0, ST_OK);
		for (int j = 0; j < 12; j++)
			run_cmd(8'h05, 8'h05, 8'h01, 8'h00, 32'h0000_0100, 0, j > 5, okSt[j % 6]);
		for (int j = 0; j < 40; j++)
		begin
			c = 8'($urandom);
			if (c == CMD_TEXT_MODE)
				c = 8'h8A;
			run_cmd(8'h05, c, 8'($urandom), 8'($urandom), $urandom,
				($urandom % 5) == 0, 1'($urandom), okSt[$urandom % 6]);
		end
		run_cmd(8'h05, CMD_TEXT_MODE, 8'h00, 8'h00, 32'h0, 0, 1, ST_OK);
		compares++;
		if (textMode !== 1'b0) err("stored switch acted");
		run_cmd(8'h05, CMD_TEXT_MODE, 8'h00, 8'h00, 32'h0, 0, 0, ST_OK);
		repeat (2) @(posedge clk);
		#1;
		compares++;
		if (textMode !== 1'b1 || rxReady !== 1'b0) err("text mode not entered");
		textModeExit = 1'b1;
		@(posedge clk);
		#1 textModeExit = 1'b0;
		@(posedge clk);
		#1;
		compares++;
		if (textMode !== 1'b0 || rxReady !== 1'b1) err("text mode not left");
		canMode = 1'b1;
		do_reset();
		for (int j = 0; j < 20; j++)
			run_cmd(8'h00, 8'($urandom % 139), 8'($urandom), 8'($urandom),
				$urandom, 0, 1'($urandom), okSt[$urandom % 6]);
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
